// ==== bfs_sequencer.v ====
// startup check, fault detection and recovery sequencer with ahb-lite registers
`timescale 1ns/1ps
`default_nettype none
`include "bfs_map.vh"
module bfs_sequencer #(
	parameter [31:0] HALF_CYC = `BFS_HALF_MS * `BFS_CLK_KHZ,
	parameter [31:0] FULL_CYC = `BFS_FULL_MS * `BFS_CLK_KHZ,
	parameter [31:0] LOW_SHUT_CYC = `BFS_LOW_SHUT_S * `BFS_CLK_HZ,
	parameter [31:0] HIGH_FILT_CYC = 32'h0000_1000,
	parameter [31:0] LOW_FILT_CYC = 32'h0000_1000,
	parameter [31:0] OCD_FILT_CYC = 32'h0000_0100,
	parameter [31:0] SCD_FILT_CYC = 32'h0000_0010,
	parameter [31:0] SCC_FILT_CYC = 32'h0000_0010,
	parameter [31:0] THERM_CYC = 32'h0000_1000,
	parameter [31:0] CELL_CYC = 32'h0000_1000
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	input wire cell_high_cmp,
	input wire cell_high_clear_cmp,
	input wire cell_low_cmp,
	input wire cell_low_clear_cmp,
	input wire cell_low_plain_cmp,
	input wire discharge_excess_current,
	input wire discharge_short,
	input wire charge_short,
	input wire pack_hot_fault,
	input wire pack_hot_clear_cmp,
	input wire therm_open_cmp,
	input wire therm_open_clear_cmp,
	input wire therm_short_cmp,
	input wire therm_short_clear_cmp,
	input wire open_cell_cmp,
	input wire charger_detected,
	input wire load_removed,
	output reg charge_gate_drive,
	output reg discharge_gate_drive,
	output wire thermistor_pin_o,
	output reg thermistor_pin_oe_n,
	output reg low_cell_margin_sel,
	output reg high_cell_margin_sel,
	output reg safety_check_pulse,
	output reg startup_complete,
	output reg regulator_off,
	output reg low_cell_flag,
	output reg high_cell_flag,
	output wire irq
);
	localparam [3:0] ST_START = 4'h0;
	localparam [3:0] ST_NORMAL = 4'h1;
	localparam [3:0] ST_HIGH = 4'h2;
	localparam [3:0] ST_LOW = 4'h3;
	localparam [3:0] ST_HOT = 4'h4;
	localparam [3:0] ST_CURR = 4'h5;
	localparam [3:0] ST_CSHORT = 4'h6;
	localparam [3:0] ST_OPEN = 4'h7;
	localparam [3:0] ST_SHUT = 4'h8;
	localparam [1:0] SC_LOW = 2'h0;
	localparam [1:0] SC_TSHORT = 2'h1;
	localparam [1:0] SC_CELL = 2'h2;
	localparam NF = 10;

	function [31:0] fcount;
		input integer i;
		begin
			case (i)
			0: fcount = HIGH_FILT_CYC;
			1: fcount = LOW_FILT_CYC;
			2: fcount = OCD_FILT_CYC;
			3: fcount = SCD_FILT_CYC;
			4: fcount = SCC_FILT_CYC;
			8: fcount = CELL_CYC;
			9: fcount = CELL_CYC;
			default: fcount = THERM_CYC;
			endcase
		end
	endfunction

	reg [3:0] state_r;
	reg [3:0] state_nxt;
	reg [1:0] cause_r;
	reg [1:0] cause_nxt;
	reg [31:0] su_cnt_r;
	reg [31:0] low_cnt_r;
	reg [3:0] su_fault_r;
	reg [`BFS_CTRL_W-1:0] ctrl_r;
	reg [`BFS_INT_W-1:0] int_stat_r;
	reg [`BFS_INT_W-1:0] int_mask_r;
	reg [`BFS_INT_W-1:0] ev;
	reg wr_pend_r;
	reg [7:0] wr_addr_r;
	wire [NF-1:0] fcond;
	wire [NF-1:0] fhit;
	wire low_ok;
	wire ahb_go;

	// filters only look at comparators once startup is done
	assign fcond = {~open_cell_cmp, open_cell_cmp, therm_short_cmp, therm_open_cmp,
		pack_hot_fault, charge_short, discharge_short, discharge_excess_current,
		cell_low_cmp, cell_high_cmp};

	genvar gi;
	generate
		for (gi = 0; gi < NF; gi = gi + 1) begin : g_filt
			bfs_filter #(
				.CNT(fcount(gi))
			) u_filt (
				.hclk(hclk),
				.hresetn(hresetn),
				.en(startup_complete),
				.cond(fcond[gi]),
				.hit(fhit[gi])
			);
		end
	endgenerate

	assign low_ok = ctrl_r[`BFS_CTRL_LOW_BYPASS] ? cell_low_plain_cmp : cell_low_clear_cmp;

	always @* begin
		state_nxt = state_r;
		cause_nxt = cause_r;
		case (state_r)
		ST_START: begin
			if (su_cnt_r == FULL_CYC - 32'h0000_0001) begin
				// only faults still present at the end count
				if (su_fault_r[2] || su_fault_r[3]) begin
					state_nxt = ST_CURR;
				end else if (su_fault_r[0]) begin
					state_nxt = ST_LOW;
				end else if (su_fault_r[1]) begin
					state_nxt = ST_HIGH;
				end else begin
					state_nxt = ST_NORMAL;
				end
			end
		end
		ST_NORMAL: begin
			if (fhit[7]) begin
				state_nxt = ST_SHUT;
				cause_nxt = SC_TSHORT;
			end else if (fhit[8]) begin
				state_nxt = ST_SHUT;
				cause_nxt = SC_CELL;
			end else if (fhit[4]) begin
				state_nxt = ST_CSHORT;
			end else if (fhit[2] || fhit[3]) begin
				state_nxt = ST_CURR;
			end else if (fhit[5]) begin
				state_nxt = ST_HOT;
			end else if (fhit[6]) begin
				state_nxt = ST_OPEN;
			end else if (fhit[1]) begin
				state_nxt = ST_LOW;
			end else if (fhit[0]) begin
				state_nxt = ST_HIGH;
			end
		end
		ST_HIGH: begin
			if (cell_high_clear_cmp) begin
				state_nxt = ST_NORMAL;
			end
		end
		ST_LOW: begin
			if (ctrl_r[`BFS_CTRL_LOW_TIMER] && low_cnt_r == LOW_SHUT_CYC) begin
				state_nxt = ST_SHUT;
				cause_nxt = SC_LOW;
			end else if (low_ok && (!ctrl_r[`BFS_CTRL_LOW_UNLOAD] || load_removed)) begin
				state_nxt = ST_NORMAL;
			end
		end
		ST_HOT: begin
			if (pack_hot_clear_cmp && (!ctrl_r[`BFS_CTRL_HOT_UNLOAD] || load_removed)) begin
				state_nxt = ST_NORMAL;
			end
		end
		ST_CURR: begin
			if (load_removed && (!ctrl_r[`BFS_CTRL_LATCHED] || charger_detected)) begin
				state_nxt = ST_NORMAL;
			end
		end
		ST_CSHORT: begin
			if (!charger_detected) begin
				state_nxt = ST_NORMAL;
			end
		end
		ST_OPEN: begin
			if (therm_open_clear_cmp) begin
				state_nxt = ST_NORMAL;
			end
		end
		ST_SHUT: begin
			if (charger_detected) begin
				if (cause_r == SC_LOW) begin
					state_nxt = ST_START;
				end else if (cause_r == SC_TSHORT && therm_short_clear_cmp) begin
					state_nxt = ST_START;
				end else if (cause_r == SC_CELL && fhit[9]) begin
					state_nxt = ST_START;
				end
			end
		end
		default: begin
			state_nxt = ST_START;
		end
		endcase
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= ST_START;
			cause_r <= SC_LOW;
		end else begin
			state_r <= state_nxt;
			cause_r <= cause_nxt;
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			su_cnt_r <= 32'h0000_0000;
			su_fault_r <= 4'h0;
			safety_check_pulse <= 1'b0;
		end else if (state_r != ST_START) begin
			su_cnt_r <= 32'h0000_0000;
			su_fault_r <= 4'h0;
			safety_check_pulse <= 1'b0;
		end else begin
			su_cnt_r <= su_cnt_r + 32'h0000_0001;
			safety_check_pulse <= (su_cnt_r == HALF_CYC - 32'h0000_0001);
			if (safety_check_pulse) begin
				su_fault_r <= {discharge_short, discharge_excess_current,
					cell_high_cmp, cell_low_cmp};
			end else if (su_cnt_r > HALF_CYC) begin
				su_fault_r <= su_fault_r & {discharge_short, discharge_excess_current,
					cell_high_cmp, cell_low_cmp};
			end
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			low_cnt_r <= 32'h0000_0000;
		end else if (state_r != ST_LOW || cell_low_clear_cmp) begin
			low_cnt_r <= 32'h0000_0000;
		end else if (low_cnt_r != LOW_SHUT_CYC) begin
			low_cnt_r <= low_cnt_r + 32'h0000_0001;
		end
	end

	assign thermistor_pin_o = 1'b0;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			charge_gate_drive <= 1'b0;
			discharge_gate_drive <= 1'b0;
			thermistor_pin_oe_n <= 1'b1;
			low_cell_margin_sel <= 1'b1;
			high_cell_margin_sel <= 1'b1;
			startup_complete <= 1'b0;
			regulator_off <= 1'b0;
			low_cell_flag <= 1'b0;
			high_cell_flag <= 1'b0;
		end else begin
			// startup forces drives off, margins on
			startup_complete <= (state_nxt != ST_START);
			charge_gate_drive <= (state_nxt == ST_NORMAL) || (state_nxt == ST_HIGH ? 1'b0 :
				(state_nxt == ST_LOW && charger_detected));
			discharge_gate_drive <= (state_nxt == ST_NORMAL) || (state_nxt == ST_HIGH);
			low_cell_margin_sel <= (state_nxt == ST_START) || !ctrl_r[`BFS_CTRL_LOW_BYPASS];
			high_cell_margin_sel <= 1'b1;
			thermistor_pin_oe_n <= !(state_nxt == ST_HIGH && ctrl_r[`BFS_CTRL_CHG_INHIBIT]);
			regulator_off <= (state_nxt == ST_SHUT);
			low_cell_flag <= (state_nxt == ST_LOW);
			high_cell_flag <= (state_nxt == ST_HIGH);
		end
	end

	always @* begin
		ev = {`BFS_INT_W{1'b0}};
		ev[`BFS_INT_FAULT] = (state_r == ST_NORMAL || state_r == ST_START) &&
			state_nxt != ST_NORMAL && state_nxt != ST_START;
		ev[`BFS_INT_DONE] = (state_r == ST_START) && (state_nxt != ST_START);
		ev[`BFS_INT_SHUT] = (state_r != ST_SHUT) && (state_nxt == ST_SHUT);
		ev[`BFS_INT_RECOVER] = (state_r != ST_NORMAL) && (state_r != ST_START) &&
			(state_nxt == ST_NORMAL);
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign ahb_go = hsel && htrans[1] && hready;
	assign irq = |(int_stat_r & int_mask_r);

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			hrdata <= 32'h0000_0000;
		end else begin
			wr_pend_r <= ahb_go && hwrite;
			if (ahb_go) begin
				wr_addr_r <= haddr[7:0];
			end
			if (ahb_go && !hwrite) begin
				case (haddr[7:0])
				`BFS_OFS_CTRL: hrdata <= {26'h0000000, ctrl_r};
				`BFS_OFS_STATUS: hrdata <= {20'h00000, su_fault_r, 1'b0, high_cell_flag,
					low_cell_flag, regulator_off, state_r[3:0]} |
					{24'h000000, startup_complete, 7'h00};
				`BFS_OFS_INT_STAT: hrdata <= {28'h0000000, int_stat_r};
				`BFS_OFS_INT_MASK: hrdata <= {28'h0000000, int_mask_r};
				default: hrdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_r <= `BFS_CTRL_RST;
			int_mask_r <= `BFS_INT_MASK_RST;
			int_stat_r <= {`BFS_INT_W{1'b0}};
		end else begin
			if (wr_pend_r && wr_addr_r == `BFS_OFS_CTRL) begin
				ctrl_r <= hwdata[`BFS_CTRL_W-1:0];
			end
			if (wr_pend_r && wr_addr_r == `BFS_OFS_INT_MASK) begin
				int_mask_r <= hwdata[`BFS_INT_W-1:0];
			end
			// set wins over write-one-to-clear
			if (wr_pend_r && wr_addr_r == `BFS_OFS_INT_STAT) begin
				int_stat_r <= (int_stat_r & ~hwdata[`BFS_INT_W-1:0]) | ev;
			end else begin
				int_stat_r <= int_stat_r | ev;
			end
		end
	end
endmodule // bfs_sequencer
`default_nettype wire

// ==== bfs_map.vh ====
// register map, field positions, reset values and timing figures of the fault sequencer
`ifndef BFS_MAP_VH
`define BFS_MAP_VH
`define BFS_OFS_CTRL 8'h00
`define BFS_OFS_STATUS 8'h04
`define BFS_OFS_INT_STAT 8'h08
`define BFS_OFS_INT_MASK 8'h0C
`define BFS_CTRL_CHG_INHIBIT 0
`define BFS_CTRL_LOW_UNLOAD 1
`define BFS_CTRL_HOT_UNLOAD 2
`define BFS_CTRL_LATCHED 3
`define BFS_CTRL_LOW_TIMER 4
`define BFS_CTRL_LOW_BYPASS 5
`define BFS_CTRL_W 6
`define BFS_CTRL_RST 6'h00
`define BFS_INT_FAULT 0
`define BFS_INT_DONE 1
`define BFS_INT_SHUT 2
`define BFS_INT_RECOVER 3
`define BFS_INT_W 4
`define BFS_INT_MASK_RST 4'h0
`define BFS_CLK_KHZ 200000
`define BFS_HALF_MS 50
`define BFS_FULL_MS 100
`define BFS_LOW_SHUT_S 8
`define BFS_CLK_HZ 200000000
`endif

// ==== bfs_filter.v ====
// fault filter timer: flags a condition that holds for a set number of cycles
`timescale 1ns/1ps
`default_nettype none
module bfs_filter #(
	parameter [31:0] CNT = 32'h0000_0001
) (
	input wire hclk,
	input wire hresetn,
	input wire en,
	input wire cond,
	output wire hit
);
	reg [31:0] cnt_r;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r <= 32'h0000_0000;
		end else if (!en || !cond) begin
			cnt_r <= 32'h0000_0000;
		end else if (cnt_r != CNT) begin
			cnt_r <= cnt_r + 32'h0000_0001;
		end
	end
	assign hit = (cnt_r == CNT);
endmodule // bfs_filter
`default_nettype wire

// ==== bfs_seq_monitor.sv ====
// port assertions for the fault sequencer
`timescale 1ns/1ps
`default_nettype none
module bfs_seq_monitor #(
	parameter [31:0] HALF_CYC = 32'h0000_0014,
	parameter [31:0] FULL_CYC = 32'h0000_0028
) (
	input wire hclk,
	input wire hresetn,
	input wire charge_gate_drive,
	input wire discharge_gate_drive,
	input wire thermistor_pin_oe_n,
	input wire low_cell_margin_sel,
	input wire high_cell_margin_sel,
	input wire safety_check_pulse,
	input wire startup_complete,
	input wire regulator_off,
	input wire low_cell_flag,
	input wire high_cell_flag
);
	reg [31:0] cnt_r;
	reg first_r;
	// cycles since release, first startup only
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r <= 32'h0;
			first_r <= 1'b1;
		end else begin
			if (!startup_complete)
				cnt_r <= cnt_r + 32'h1;
			if (startup_complete)
				first_r <= 1'b0;
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_start_drives:
	assert property (!startup_complete |-> !charge_gate_drive && !discharge_gate_drive)
		else $error("gate drive on before startup");
	a_start_margins:
	assert property (!startup_complete |-> low_cell_margin_sel && high_cell_margin_sel)
		else $error("margin select low before startup");
	a_pulse_single:
	assert property (safety_check_pulse |=> !safety_check_pulse && !startup_complete)
		else $error("check pulse longer than one cycle");
	a_pulse_time:
	assert property (first_r && safety_check_pulse |-> cnt_r == HALF_CYC)
		else $error("check pulse at wrong cycle");
	a_done_time:
	assert property (first_r && $rose(startup_complete) |-> cnt_r == FULL_CYC)
		else $error("startup completion at wrong cycle");
	a_high_drives:
	assert property (high_cell_flag |-> !charge_gate_drive && discharge_gate_drive)
		else $error("wrong drives in high cell state");
	a_low_drives:
	assert property (low_cell_flag |-> !discharge_gate_drive)
		else $error("discharge on in low cell state");
	a_shut_drives:
	assert property (regulator_off |-> !charge_gate_drive && !discharge_gate_drive)
		else $error("drive on in shutdown");
	a_pin_pull:
	assert property (!thermistor_pin_oe_n |-> high_cell_flag)
		else $error("thermistor pin pulled outside high cell state");
endmodule // bfs_seq_monitor
`default_nettype wire

// ==== bfs_pack_model.sv ====
// pack model: comparator levels from commanded cell and thermistor conditions
`timescale 1ns/1ps
`default_nettype none
module bfs_pack_model (
	input wire [8:0] fault_cmd,
	input wire thermistor_pin_oe_n,
	input wire thermistor_pin_o,
	input wire low_band,
	output wire [14:0] cmp,
	output wire ts_level
);
	// clear comparators are the inverse of the trip ones; low clear is also held low in the low band
	// low band: cells above plain threshold but under threshold plus margin
	assign cmp = {fault_cmd[8], !fault_cmd[7], fault_cmd[7], !fault_cmd[6], fault_cmd[6],
		!fault_cmd[5], fault_cmd[5:2], !fault_cmd[1], !(fault_cmd[1] || low_band), fault_cmd[1],
		!fault_cmd[0], fault_cmd[0]};
	// pin pulled up unless driven low
	assign ts_level = thermistor_pin_oe_n ? 1'b1 : thermistor_pin_o;
endmodule // bfs_pack_model
`default_nettype wire

// ==== test_bfs_sequencer.sv ====
// self-checking bench for the fault sequencer
`timescale 1ns/1ps
`default_nettype none
module test_bfs_sequencer;
	localparam [31:0] HALF = 32'h0000_0014;
	localparam [31:0] FULL = 32'h0000_0028;
	reg hclk = 1'b0;
	reg hresetn = 1'b0;
	reg hsel = 1'b0;
	reg hwrite = 1'b0;
	reg [1:0] htrans = 2'h0;
	reg [2:0] hsize = 3'h2;
	reg [31:0] haddr = 32'h0;
	reg [31:0] hwdata = 32'h0;
	reg [8:0] fault_cmd = 9'h0;
	reg charger = 1'b0;
	reg unload = 1'b0;
	reg low_band = 1'b0;
	reg b;
	reg [31:0] rd;
	wire [31:0] hrdata;
	wire [14:0] cmp;
	wire hreadyout, hresp, cgd, dgd, pin_o, pin_oe_n, lmsel, hmsel, pulse, done, roff, lflag;
	wire hflag, irq, ts;
	int mismatches = 0;
	int comparisons = 0;
	int cyc = 0;
	int n, pn, k, lat;
	always #2.5 hclk = ~hclk;
	bfs_sequencer #(.HALF_CYC(HALF), .FULL_CYC(FULL), .LOW_SHUT_CYC(32'h1E),
		.HIGH_FILT_CYC(32'h6), .LOW_FILT_CYC(32'h6), .OCD_FILT_CYC(32'h6),
		.SCD_FILT_CYC(32'h6), .SCC_FILT_CYC(32'h6), .THERM_CYC(32'h8), .CELL_CYC(32'h5))
	bfs_sequencer_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cell_high_cmp(cmp[0]),
		.cell_high_clear_cmp(cmp[1]), .cell_low_cmp(cmp[2]), .cell_low_clear_cmp(cmp[3]),
		.cell_low_plain_cmp(cmp[4]), .discharge_excess_current(cmp[5]),
		.discharge_short(cmp[6]), .charge_short(cmp[7]), .pack_hot_fault(cmp[8]),
		.pack_hot_clear_cmp(cmp[9]), .therm_open_cmp(cmp[10]), .therm_open_clear_cmp(cmp[11]),
		.therm_short_cmp(cmp[12]), .therm_short_clear_cmp(cmp[13]), .open_cell_cmp(cmp[14]),
		.charger_detected(charger), .load_removed(unload), .charge_gate_drive(cgd),
		.discharge_gate_drive(dgd), .thermistor_pin_o(pin_o), .thermistor_pin_oe_n(pin_oe_n),
		.low_cell_margin_sel(lmsel), .high_cell_margin_sel(hmsel), .safety_check_pulse(pulse),
		.startup_complete(done), .regulator_off(roff), .low_cell_flag(lflag),
		.high_cell_flag(hflag), .irq(irq));
	bfs_pack_model bfs_pack_model_i (.fault_cmd(fault_cmd), .thermistor_pin_oe_n(pin_oe_n),
		.thermistor_pin_o(pin_o), .low_band(low_band), .cmp(cmp), .ts_level(ts));
	task summarize;
		if (mismatches == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task check(input [31:0] seen, input [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			summarize;
		end
	end
	task ahb(input w, input [31:0] a, input [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		#1;
	endtask
	task rdchk(input [31:0] a, input [31:0] m, input [31:0] e);
		ahb(1'b0, a, 32'h0);
		check(rd & m, e);
	endtask
	task wait_st(input [3:0] st);
		for (k = 0; k < 100; k++) begin
			ahb(1'b0, 32'h4, 32'h0);
			if (rd[3:0] === st)
				break;
		end
		check(rd[3:0], st);
	endtask
	task set_in(input [8:0] f, input c, input u);
		@(posedge hclk);
		fault_cmd <= f;
		charger <= c;
		unload <= u;
		#1;
	endtask
	task idle(input int c);
		repeat (c) @(posedge hclk);
		#1;
	endtask
	task do_reset;
		hresetn <= 1'b0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
	endtask
	task startup(input clr);
		n = 0;
		pn = 0;
		while (done !== 1'b1 && n < 400) begin
			@(posedge hclk);
			if (clr && n == FULL - 3)
				fault_cmd <= 9'h0;
			#1;
			n++;
			if (pulse === 1'b1)
				pn = n;
		end
	endtask
	initial begin
		k = $urandom(32'h5284A1EF);
		fault_cmd <= 9'h080;
		do_reset;
		startup(1'b1);
		check(n, FULL);
		check(pn, HALF);
		check({cgd, dgd, hmsel, lmsel}, 4'hF);
		rdchk(32'h4, 32'hFF, 32'h81);
		rdchk(32'h0, 32'hFFFF_FFFF, 32'h0);
		rdchk(32'hC, 32'hFFFF_FFFF, 32'h0);
		ahb(1'b1, 32'h10, 32'hFFFF_FFFF);
		rdchk(32'h10, 32'hFFFF_FFFF, 32'h0);
		rdchk(32'h8, 32'hF, 32'h2);
		ahb(1'b1, 32'hC, 32'h2);
		check(irq, 1'b1);
		ahb(1'b1, 32'h8, 32'h2);
		check(irq, 1'b0);
		ahb(1'b1, 32'hC, 32'hF);
		b = $urandom;
		ahb(1'b1, 32'h0, {31'h0, b});
		set_in(9'h001, 1'b0, 1'b0);
		wait_st(4'h2);
		check({cgd, dgd, pin_oe_n, ts, irq}, {2'b01, ~b, ~b, 1'b1});
		set_in(9'h000, 1'b0, 1'b0);
		wait_st(4'h1);
		check({cgd, dgd, pin_oe_n}, 3'b111);
		rdchk(32'h8, 32'hF, 32'h9);
		ahb(1'b1, 32'h8, 32'hF);
		check(irq, 1'b0);
		for (lat = 0; lat < 2; lat++) begin
			ahb(1'b1, 32'h0, lat << 3);
			set_in(lat ? 9'h008 : 9'h004, 1'b0, 1'b0);
			repeat (10 + $urandom % 8) @(posedge hclk);
			set_in(9'h000, 1'b0, 1'b0);
			wait_st(4'h5);
			check({cgd, dgd}, 2'b00);
			set_in(9'h000, 1'b0, 1'b1);
			if (lat) begin
				idle(10);
				rdchk(32'h4, 32'hF, 32'h5);
				set_in(9'h000, 1'b1, 1'b1);
			end
			wait_st(4'h1);
			check({cgd, dgd}, 2'b11);
			set_in(9'h000, 1'b0, 1'b0);
		end
		ahb(1'b1, 32'h0, 32'h0);
		set_in(9'h002, 1'b0, 1'b0);
		wait_st(4'h3);
		check({cgd, dgd, lflag}, 3'b001);
		set_in(9'h002, 1'b1, 1'b0);
		idle(3);
		check({cgd, dgd}, 2'b10);
		set_in(9'h000, 1'b0, 1'b0);
		wait_st(4'h1);
		check({cgd, dgd}, 2'b11);
		ahb(1'b1, 32'h0, 32'h4);
		set_in(9'h020, 1'b0, 1'b0);
		wait_st(4'h4);
		check({cgd, dgd}, 2'b00);
		set_in(9'h000, 1'b0, 1'b0);
		idle(12);
		rdchk(32'h4, 32'hF, 32'h4);
		set_in(9'h000, 1'b0, 1'b1);
		wait_st(4'h1);
		ahb(1'b1, 32'h0, 32'h0);
		set_in(9'h010, 1'b1, 1'b0);
		wait_st(4'h6);
		check({cgd, dgd}, 2'b00);
		set_in(9'h000, 1'b1, 1'b0);
		idle(10);
		rdchk(32'h4, 32'hF, 32'h6);
		set_in(9'h000, 1'b0, 1'b0);
		wait_st(4'h1);
		set_in(9'h040, 1'b0, 1'b0);
		wait_st(4'h7);
		check({cgd, dgd}, 2'b00);
		set_in(9'h000, 1'b0, 1'b0);
		wait_st(4'h1);
		set_in(9'h100, 1'b0, 1'b0);
		wait_st(4'h8);
		check({roff, cgd, dgd}, 3'b100);
		set_in(9'h000, 1'b1, 1'b0);
		for (k = 0; k < 100 && roff !== 1'b0; k++)
			idle(1);
		startup(1'b0);
		check(pn > 0, 1'b1);
		check(n, FULL);
		check({done, cgd, dgd}, 3'b111);
		set_in(9'h080, 1'b0, 1'b0);
		wait_st(4'h8);
		set_in(9'h080, 1'b1, 1'b0);
		idle(10);
		rdchk(32'h4, 32'h1F, 32'h18);
		set_in(9'h000, 1'b1, 1'b0);
		for (k = 0; k < 100 && roff !== 1'b0; k++)
			idle(1);
		startup(1'b0);
		check(n, FULL);
		ahb(1'b1, 32'h0, 32'h10);
		set_in(9'h002, 1'b0, 1'b0);
		wait_st(4'h8);
		check({roff, lflag, cgd, dgd}, 4'b1000);
		set_in(9'h000, 1'b1, 1'b0);
		for (k = 0; k < 100 && roff !== 1'b0; k++)
			idle(1);
		startup(1'b0);
		check(n, FULL);
		ahb(1'b1, 32'h0, 32'h22);
		set_in(9'h002, 1'b0, 1'b1);
		check(lmsel, 1'b0);
		wait_st(4'h3);
		@(posedge hclk);
		fault_cmd <= 9'h000;
		low_band <= 1'b1;
		wait_st(4'h1);
		ahb(1'b1, 32'h0, 32'h0);
		@(posedge hclk);
		low_band <= 1'b0;
		set_in(9'h000, 1'b0, 1'b0);
		fault_cmd <= 9'h002;
		do_reset;
		startup(1'b1);
		rdchk(32'h4, 32'hF, 32'h1);
		fault_cmd <= 9'h002;
		do_reset;
		startup(1'b0);
		check(n, FULL);
		rdchk(32'h4, 32'hFFF, 32'h0A3);
		check({cgd, dgd}, 2'b00);
		set_in(9'h000, 1'b0, 1'b0);
		wait_st(4'h1);
		summarize;
	end
endmodule // test_bfs_sequencer
bind bfs_sequencer bfs_seq_monitor #(.HALF_CYC(HALF_CYC), .FULL_CYC(FULL_CYC))
bfs_seq_monitor_i (.hclk, .hresetn, .charge_gate_drive, .discharge_gate_drive,
	.thermistor_pin_oe_n, .low_cell_margin_sel, .high_cell_margin_sel, .safety_check_pulse,
	.startup_complete, .regulator_off, .low_cell_flag, .high_cell_flag);
`default_nettype wire
